// file: core/scm_clock_ctrl.sv
// Purpose: clock source selection, division and halt-mode gating
// Assumes: oscillator ticks and halt/wake pulses synchronous to clk_i
// Notes: clocks leave as one-cycle enables, never as gated clocks
`timescale 1ns/1ps
module scm_clock_ctrl #(
  parameter int STB_TICKS = scm_pkg::STB_TICKS_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic internal_fast_rc_osc_tick_i,
  input wire logic hxt_tick_i,
  input wire logic internal_slow_rc_osc_tick_i,
  input wire logic lxt_tick_i,
  input wire logic halt_i,
  input wire logic wake_i,
  input wire logic watchdog_timer_en_i,
  output scm_pkg::scm_clk_en_t clk_en_o,
  output scm_pkg::scm_osc_run_t osc_run_o,
  output logic cpu_run_o,
  output logic [3:0] irc_mhz_o
);

  // ----------------------------------------
  // registers and state
  // ----------------------------------------
  scm_pkg::scm_scc_t scc_reg;
  scm_pkg::scm_scc_t act_reg;
  scm_pkg::scm_mode_t mode_reg;
  logic [1:0] irc_freq_reg;
  logic [1:0] irc_freq_act_reg;
  logic irc_en_reg;
  logic hxt_drv_reg;
  logic hxt_en_reg;
  logic lxt_spd_reg;
  logic lxt_en_reg;
  logic ack_reg;
  logic sw_busy_reg;
  logic sw_applied_reg;
  logic [2:0] sw_cnt_reg;
  logic [5:0] div_cnt_reg;
  logic [7:0] rd_next;
  logic [2:0] stb_reg;
  logic [2:0] osc_run;
  logic [2:0] osc_tick;
  logic [2:0] osc_restart;
  logic wr_stb;
  logic irc_restart;
  logic fh_keep;
  logic fsub_keep;
  logic sys_keep;
  logic slow_rc_run;
  logic fh_raw;
  logic fsub_raw;
  logic sys_raw;
  logic div_hit;
  logic [5:0] div_mask;
  logic slow_xt_sys;
  logic sw_req;

  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  // writes land on the edge where the master sees ack
  assign wr_stb = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg & wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_cyc_i & wb_stb_i & ~ack_reg;
    end
  end

  always_comb begin
    rd_next = 8'h00;
    if (wb_adr_i == scm_pkg::ADR_SCC) begin
      rd_next = {scc_reg.sysclk_select, 1'b0, scc_reg.high_speed_source_sel,
                 scc_reg.low_speed_source_sel, scc_reg.high_osc_halt_enable, scc_reg.low_osc_halt_enable};
    end else if (wb_adr_i == scm_pkg::ADR_IRC) begin
      rd_next = {4'h0, irc_freq_reg, stb_reg[0], irc_en_reg};
    end else if (wb_adr_i == scm_pkg::ADR_HXT) begin
      rd_next = {5'h00, hxt_drv_reg, stb_reg[1], hxt_en_reg};
    end else if (wb_adr_i == scm_pkg::ADR_LXT) begin
      rd_next = {5'h00, lxt_spd_reg, stb_reg[2], lxt_en_reg};
    end else if (wb_adr_i == scm_pkg::ADR_STAT) begin
      rd_next = {3'h0, mode_reg == scm_pkg::MODE_RUN ? 3'h0 : 3'h1, ~cpu_run_o, sw_busy_reg};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
      wb_ack_o <= 1'b0;
    end else begin
      wb_dat_o <= {24'h00_0000, rd_next};
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~ack_reg;
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  assign slow_xt_sys = (act_reg.sysclk_select == scm_pkg::CKS_SUB) & act_reg.low_speed_source_sel;
  assign irc_restart = wr_stb & (wb_adr_i == scm_pkg::ADR_IRC)
                       & (wb_dat_i[scm_pkg::IRC_FREQ_LSB +: 2] != irc_freq_reg);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scc_reg <= scm_pkg::SCC_RST;
      irc_freq_reg <= scm_pkg::IRC_FREQ_RST;
      irc_en_reg <= scm_pkg::IRC_EN_RST;
      hxt_drv_reg <= 1'b0;
      hxt_en_reg <= 1'b0;
      lxt_spd_reg <= 1'b0;
      lxt_en_reg <= 1'b0;
    end else if (wr_stb) begin
      if (wb_adr_i == scm_pkg::ADR_SCC) begin
        scc_reg <= {wb_dat_i[7:5], wb_dat_i[3:0]};
      end else if (wb_adr_i == scm_pkg::ADR_IRC) begin
        irc_freq_reg <= wb_dat_i[scm_pkg::IRC_FREQ_LSB +: 2];
        irc_en_reg <= wb_dat_i[scm_pkg::EN_BIT];
      end else if (wb_adr_i == scm_pkg::ADR_HXT) begin
        // drive strength is frozen while the crystal runs
        if (!hxt_en_reg) begin
          hxt_drv_reg <= wb_dat_i[scm_pkg::MODE_BIT];
        end
        hxt_en_reg <= wb_dat_i[scm_pkg::EN_BIT];
      end else if (wb_adr_i == scm_pkg::ADR_LXT) begin
        if (!slow_xt_sys) begin
          lxt_spd_reg <= wb_dat_i[scm_pkg::MODE_BIT];
        end
        lxt_en_reg <= wb_dat_i[scm_pkg::EN_BIT];
      end
    end
  end

  // ----------------------------------------
  // operating mode
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_reg <= scm_pkg::MODE_RUN;
    end else begin
      case (mode_reg)
        scm_pkg::MODE_RUN: begin
          if (halt_i) begin
            case ({scc_reg.high_osc_halt_enable, scc_reg.low_osc_halt_enable})
              2'b00: mode_reg <= scm_pkg::MODE_SLEEP;
              2'b01: mode_reg <= scm_pkg::MODE_IDLE_LOW_ONLY;
              2'b11: mode_reg <= scm_pkg::MODE_IDLE_BOTH_OSC;
              default: mode_reg <= scm_pkg::MODE_IDLE_HIGH_ONLY;
            endcase
          end
        end
        default: begin
          if (wake_i) begin
            mode_reg <= scm_pkg::MODE_RUN;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // oscillator keep-alive and stable flags
  // ----------------------------------------
  assign fh_keep = mode_reg[0] | mode_reg[2] | mode_reg[3];
  assign fsub_keep = mode_reg[0] | mode_reg[1] | mode_reg[2];
  assign sys_keep = mode_reg[0] | mode_reg[2]
                    | (mode_reg[1] & (act_reg.sysclk_select == scm_pkg::CKS_SUB))
                    | (mode_reg[3] & (act_reg.sysclk_select != scm_pkg::CKS_SUB));
  assign slow_rc_run = ~mode_reg[4] | watchdog_timer_en_i;
  // fast oscillators follow their enable bits in slow mode too
  assign osc_run = {lxt_en_reg & fsub_keep, hxt_en_reg & fh_keep, irc_en_reg & fh_keep};
  assign osc_tick = {lxt_tick_i, hxt_tick_i, internal_fast_rc_osc_tick_i};
  assign osc_restart = {1'b0, 1'b0, irc_restart};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_stb
      logic [15:0] cnt_reg;
      always_ff @(posedge clk_i) begin
        if (rst_i || !osc_run[gi] || osc_restart[gi]) begin
          cnt_reg <= 16'h0000;
          stb_reg[gi] <= 1'b0;
        end else if (osc_tick[gi] && !stb_reg[gi]) begin
          cnt_reg <= cnt_reg + 16'h0001;
          if (cnt_reg == 16'(STB_TICKS - 1)) begin
            stb_reg[gi] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irc_freq_act_reg <= scm_pkg::IRC_FREQ_RST;
    end else if (stb_reg[0]) begin
      irc_freq_act_reg <= irc_freq_reg;
    end
  end

  // ----------------------------------------
  // source muxing and divider
  // ----------------------------------------
  assign fh_raw = act_reg.high_speed_source_sel ? (hxt_tick_i & stb_reg[1] & osc_run[1])
                                                : (internal_fast_rc_osc_tick_i & stb_reg[0] & osc_run[0]);
  assign fsub_raw = act_reg.low_speed_source_sel ? (lxt_tick_i & stb_reg[2] & osc_run[2])
                                                 : (internal_slow_rc_osc_tick_i & slow_rc_run);
  assign div_mask = 6'((7'h01 << act_reg.sysclk_select) - 7'h01);
  assign div_hit = (div_cnt_reg & div_mask) == div_mask;
  assign sys_raw = (act_reg.sysclk_select == scm_pkg::CKS_SUB) ? fsub_raw : (fh_raw & div_hit);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt_reg <= 6'h00;
    end else if (fh_raw) begin
      div_cnt_reg <= div_cnt_reg + 6'h01;
    end
  end

  // ----------------------------------------
  // clock switching
  // ----------------------------------------
  // swap only on a sys tick so no short period escapes
  assign sw_req = wr_stb & (wb_adr_i == scm_pkg::ADR_SCC)
                  & ({wb_dat_i[7:5], wb_dat_i[3:2]} != {scc_reg.sysclk_select,
                     scc_reg.high_speed_source_sel, scc_reg.low_speed_source_sel});

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      act_reg <= scm_pkg::SCC_RST;
      sw_busy_reg <= 1'b0;
      sw_applied_reg <= 1'b0;
      sw_cnt_reg <= 3'h0;
    end else if (sw_req) begin
      sw_busy_reg <= 1'b1;
      sw_applied_reg <= 1'b0;
      sw_cnt_reg <= 3'h0;
    end else if (sw_busy_reg && sys_raw) begin
      if (!sw_applied_reg) begin
        sw_cnt_reg <= sw_cnt_reg + 3'h1;
        if (sw_cnt_reg == scm_pkg::SW_SYS_TICKS - 3'h1) begin
          act_reg <= scc_reg;
          sw_applied_reg <= 1'b1;
        end
      end else begin
        sw_busy_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_en_o <= '0;
      osc_run_o <= '0;
      cpu_run_o <= 1'b0;
      irc_mhz_o <= scm_pkg::MHZ_4;
    end else begin
      clk_en_o.sys <= sys_raw & sys_keep;
      clk_en_o.fh <= fh_raw & fh_keep;
      clk_en_o.fsub <= fsub_raw & fsub_keep;
      clk_en_o.slow_rc <= internal_slow_rc_osc_tick_i & slow_rc_run;
      osc_run_o <= {osc_run[0], osc_run[1], slow_rc_run, osc_run[2]};
      cpu_run_o <= mode_reg == scm_pkg::MODE_RUN;
      case (irc_freq_act_reg)
        2'b01: irc_mhz_o <= scm_pkg::MHZ_8;
        2'b10: irc_mhz_o <= scm_pkg::MHZ_12;
        default: irc_mhz_o <= scm_pkg::MHZ_4;
      endcase
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_sleep_stops;
    @(posedge clk_i) disable iff (rst_i)
      (mode_reg == scm_pkg::MODE_SLEEP) |=> !clk_en_o.sys && !clk_en_o.fh && !clk_en_o.fsub;
  endproperty
  a_sleep_stops: assert property (p_sleep_stops) else $error("clock ran in sleep");

  property p_sleep_rc;
    @(posedge clk_i) disable iff (rst_i)
      (mode_reg == scm_pkg::MODE_SLEEP && !watchdog_timer_en_i) |=> !clk_en_o.slow_rc && !osc_run_o[1];
  endproperty
  a_sleep_rc: assert property (p_sleep_rc) else $error("slow rc ran without watchdog");

  property p_idle_low;
    @(posedge clk_i) disable iff (rst_i)
      (mode_reg == scm_pkg::MODE_IDLE_LOW_ONLY && act_reg.sysclk_select != scm_pkg::CKS_SUB)
      |=> !clk_en_o.sys && !clk_en_o.fh;
  endproperty
  a_idle_low: assert property (p_idle_low) else $error("fast clock ran in low-only idle");

  property p_idle_both;
    @(posedge clk_i) disable iff (rst_i)
      (mode_reg == scm_pkg::MODE_IDLE_BOTH_OSC && fh_raw) |=> clk_en_o.fh;
  endproperty
  a_idle_both: assert property (p_idle_both) else $error("fast clock lost in both-osc idle");

  property p_idle_high;
    @(posedge clk_i) disable iff (rst_i)
      (mode_reg == scm_pkg::MODE_IDLE_HIGH_ONLY) |=> !clk_en_o.fsub;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("slow clock ran in high-only idle");

  property p_div1;
    @(posedge clk_i) disable iff (rst_i)
      (mode_reg == scm_pkg::MODE_RUN && act_reg.sysclk_select == 3'h0 && fh_raw) |=> clk_en_o.sys;
  endproperty
  a_div1: assert property (p_div1) else $error("undivided sys tick missing");

  property p_switch_wait;
    @(posedge clk_i) disable iff (rst_i)
      $changed(act_reg) |-> sw_cnt_reg == scm_pkg::SW_SYS_TICKS && sw_busy_reg;
  endproperty
  a_switch_wait: assert property (p_switch_wait) else $error("clock switched early");

  property p_freq_apply;
    @(posedge clk_i) disable iff (rst_i)
      $changed(irc_freq_act_reg) |-> $past(stb_reg[0]);
  endproperty
  a_freq_apply: assert property (p_freq_apply) else $error("rc frequency applied unstable");

  property p_irc_clear;
    @(posedge clk_i) disable iff (rst_i)
      irc_restart |=> !stb_reg[0] ##1 !stb_reg[0];
  endproperty
  a_irc_clear: assert property (p_irc_clear) else $error("rc stable not cleared");

  property p_speedup_frozen;
    @(posedge clk_i) disable iff (rst_i)
      slow_xt_sys |=> $stable(lxt_spd_reg);
  endproperty
  a_speedup_frozen: assert property (p_speedup_frozen) else $error("speedup changed on slow crystal");

  property p_ack;
    @(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !ack_reg) |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("wishbone ack not single");

endmodule // scm_clock_ctrl

// file: core/scm_pkg.sv
// Purpose: constants and types for the system clock mode control block
// Assumes: one 40 MHz clock, classic Wishbone, 8-bit registers in the low byte
// Notes: oscillators arrive as one-cycle tick enables
package scm_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] ADR_SCC = 8'h00;
  localparam logic [7:0] ADR_IRC = 8'h04;
  localparam logic [7:0] ADR_HXT = 8'h08;
  localparam logic [7:0] ADR_LXT = 8'h0C;
  localparam logic [7:0] ADR_STAT = 8'h10;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int IRC_FREQ_LSB = 2;
  localparam int STB_BIT = 1;
  localparam int EN_BIT = 0;
  localparam int MODE_BIT = 2;

  // ----------------------------------------
  // reset values and counts
  // ----------------------------------------
  localparam logic [1:0] IRC_FREQ_RST = 2'h0;
  localparam logic IRC_EN_RST = 1'b1;
  localparam logic [2:0] CKS_SUB = 3'h7;
  localparam logic [2:0] SW_SYS_TICKS = 3'h4;
  localparam int STB_TICKS_DEF = 1024;
  localparam logic [3:0] MHZ_4 = 4'h4;
  localparam logic [3:0] MHZ_8 = 4'h8;
  localparam logic [3:0] MHZ_12 = 4'hC;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] sysclk_select;
    logic high_speed_source_sel;
    logic low_speed_source_sel;
    logic high_osc_halt_enable;
    logic low_osc_halt_enable;
  } scm_scc_t;

  localparam scm_scc_t SCC_RST = '0;

  typedef struct packed {
    logic sys;
    logic fh;
    logic fsub;
    logic slow_rc;
  } scm_clk_en_t;

  typedef struct packed {
    logic internal_fast_rc_osc;
    logic external_fast_crystal;
    logic internal_slow_rc_osc;
    logic external_slow_crystal;
  } scm_osc_run_t;

  typedef enum logic [4:0] {
    MODE_RUN = 5'b00001,
    MODE_IDLE_LOW_ONLY = 5'b00010,
    MODE_IDLE_BOTH_OSC = 5'b00100,
    MODE_IDLE_HIGH_ONLY = 5'b01000,
    MODE_SLEEP = 5'b10000
  } scm_mode_t;

endpackage

// file: tb/scm_osc_model.sv
// Purpose: oscillator sources seen by the clock control block
// Assumes: each oscillator is a tick every P cycles of clk_i
// Notes: a stopped oscillator gives no ticks at all
`timescale 1ns/1ps
module scm_osc_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire scm_pkg::scm_osc_run_t osc_run_i,
  output logic [3:0] tick_o
);
  // ----------------------------------------
  // periods: fast rc, fast crystal, slow rc, slow crystal
  // ----------------------------------------
  localparam int P[4] = '{2, 3, 7, 5};
  logic [3:0] run;
  logic [2:0] cnt_reg [4];

  assign run = {osc_run_i.external_slow_crystal, osc_run_i.internal_slow_rc_osc,
                osc_run_i.external_fast_crystal, osc_run_i.internal_fast_rc_osc};

  // restart on run so a re-enabled oscillator starts from scratch
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 4; i++) begin
      if (rst_i || !run[i]) begin
        cnt_reg[i] <= 3'h0;
        tick_o[i] <= 1'b0;
      end else begin
        cnt_reg[i] <= (cnt_reg[i] == 3'(P[i] - 1)) ? 3'h0 : cnt_reg[i] + 3'h1;
        tick_o[i] <= (cnt_reg[i] == 3'(P[i] - 1));
      end
    end
  end
endmodule // scm_osc_model

// file: tb/test_system_clock_mode_control.sv
// Purpose: self-checking bench for the clock mode control block
// Assumes: STB_TICKS of 4, oscillator periods 2, 3, 7, 5 cycles
// Notes: rates measured over a 420-cycle window, one tick slack
`timescale 1ns/1ps
module test_system_clock_mode_control;
  localparam int W = 420;
  logic clk_i, rst_i, cyc, stb, we, halt, wake, wdt, cpu_run;
  logic [7:0] adr, cfg;
  logic [31:0] wdat, dat_o;
  logic [3:0] sel, mhz, tick, prev;
  logic ack;
  scm_pkg::scm_clk_en_t en;
  scm_pkg::scm_osc_run_t run;
  logic [3:0] mtab [4] = '{scm_pkg::MHZ_4, scm_pkg::MHZ_8, scm_pkg::MHZ_12, scm_pkg::MHZ_4};
  int fail_count, samples_checked, n_sys, n_fh, n_fsub, n_lrc;

  scm_clock_ctrl #(.STB_TICKS(4)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .internal_fast_rc_osc_tick_i(tick[0]), .hxt_tick_i(tick[1]), .internal_slow_rc_osc_tick_i(tick[2]), .lxt_tick_i(tick[3]),
    .halt_i(halt), .wake_i(wake), .watchdog_timer_en_i(wdt), .clk_en_o(en), .osc_run_o(run),
    .cpu_run_o(cpu_run), .irc_mhz_o(mhz));
  scm_osc_model osc (.clk_i(clk_i), .rst_i(rst_i), .osc_run_i(run), .tick_o(tick));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // classic cycle: hold everything until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h00_0000, d};
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 50);
    if (k >= 50) begin
      fail_count++;
      test_done();
    end
    q = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask

  task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk(nm, {24'h00_0000, q & m}, {24'h00_0000, e});
  endtask

  task automatic poll(input logic [7:0] a, input int b, input logic v);
    logic [7:0] q;
    int k;
    k = 0;
    do begin
      wb(1'b0, a, 8'h00, q);
      k++;
    end while (q[b] !== v && k < 300);
    if (k >= 300) begin
      fail_count++;
      test_done();
    end
  endtask

  task automatic pulse(input logic h);
    if (h)
      halt <= 1'b1;
    else
      wake <= 1'b1;
    @(posedge clk_i);
    halt <= 1'b0;
    wake <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic measure();
    n_sys = 0;
    n_fh = 0;
    n_fsub = 0;
    n_lrc = 0;
    repeat (W) begin
      @(posedge clk_i);
      n_sys += int'(en.sys);
      n_fh += int'(en.fh);
      n_fsub += int'(en.fsub);
      n_lrc += int'(en.slow_rc);
    end
  endtask

  task automatic near(input string nm, input int n, input int e);
    chk(nm, 32'(n >= e - 1 && n <= e + 1), 32'h1);
  endtask

  // ----------------------------------------
  // stimulus
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  initial begin
    repeat (100000) @(posedge clk_i);
    fail_count++;
    test_done();
  end

  initial begin
    fail_count = 0;
    samples_checked = 0;
    rst_i = 1'b1;
    {cyc, stb, we, halt, wake, wdt} = 6'h00;
    adr = 8'h00;
    wdat = 32'h0000_0000;
    sel = 4'h1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd("scc reset", scm_pkg::ADR_SCC, 8'hFF, 8'h00);
    rd("irc reset", scm_pkg::ADR_IRC, 8'hFD, 8'h01);
    rd("hxt reset", scm_pkg::ADR_HXT, 8'hFF, 8'h00);
    rd("lxt reset", scm_pkg::ADR_LXT, 8'hFF, 8'h00);
    rd("unmapped", 8'h14, 8'hFF, 8'h00);
    poll(scm_pkg::ADR_IRC, 1, 1'b1);
    wr(scm_pkg::ADR_SCC, 8'h10);
    rd("scc bit4", scm_pkg::ADR_SCC, 8'hFF, 8'h00);
    // ends on code 00, the configured option
    for (int c = 1; c <= 4; c++) begin
      prev = mhz;
      wr(scm_pkg::ADR_IRC, 8'hF1 | 8'((c % 4) << 2));
      rd("rc restart", scm_pkg::ADR_IRC, 8'hFF, 8'h01 | 8'((c % 4) << 2));
      chk("rc freq held", 32'(mhz), 32'(prev));
      poll(scm_pkg::ADR_IRC, 1, 1'b1);
      repeat (3) @(posedge clk_i);
      chk("rc freq", 32'(mhz), 32'(mtab[c % 4]));
    end
    for (int s = 0; s < 7; s++) begin
      wr(scm_pkg::ADR_SCC, 8'(s << 5));
      poll(scm_pkg::ADR_STAT, 0, 1'b0);
      measure();
      near("sys divide", n_sys, 210 >> s);
    end
    wr(scm_pkg::ADR_SCC, 8'hE0);
    poll(scm_pkg::ADR_STAT, 0, 1'b0);
    measure();
    near("slow rc sys", n_sys, 60);
    near("fh in slow", n_fh, 210);
    wr(scm_pkg::ADR_IRC, 8'h00);
    repeat (4) @(posedge clk_i);
    measure();
    chk("fh stopped", 32'(n_fh), 32'h0);
    chk("rc run", 32'(run.internal_fast_rc_osc), 32'h0);
    wr(scm_pkg::ADR_IRC, 8'h01);
    poll(scm_pkg::ADR_IRC, 1, 1'b1);
    wr(scm_pkg::ADR_LXT, 8'h05);
    rd("lxt enable", scm_pkg::ADR_LXT, 8'hFF, 8'h05);
    poll(scm_pkg::ADR_LXT, 1, 1'b1);
    wr(scm_pkg::ADR_SCC, 8'hE4);
    poll(scm_pkg::ADR_STAT, 0, 1'b0);
    measure();
    near("slow xtal sys", n_sys, 84);
    wr(scm_pkg::ADR_LXT, 8'h01);
    rd("speedup frozen", scm_pkg::ADR_LXT, 8'hFF, 8'h07);
    sel <= 4'h0;
    wr(scm_pkg::ADR_HXT, 8'h05);
    sel <= 4'h1;
    rd("lane off write", scm_pkg::ADR_HXT, 8'hFF, 8'h00);
    wr(scm_pkg::ADR_HXT, 8'h01);
    rd("hxt enable", scm_pkg::ADR_HXT, 8'hFF, 8'h01);
    poll(scm_pkg::ADR_HXT, 1, 1'b1);
    wr(scm_pkg::ADR_HXT, 8'h05);
    rd("drive frozen", scm_pkg::ADR_HXT, 8'hFF, 8'h03);
    wr(scm_pkg::ADR_SCC, 8'h08);
    poll(scm_pkg::ADR_STAT, 0, 1'b0);
    measure();
    near("fast xtal sys", n_sys, 140);
    // halt bits in [1:0]; upper half of the loop runs slow with watchdog on
    for (int i = 0; i < 8; i++) begin
      cfg = {(i[2] ? 3'h7 : 3'h0), 3'h0, 2'(i)};
      wdt <= i[2];
      wr(scm_pkg::ADR_SCC, cfg);
      poll(scm_pkg::ADR_STAT, 0, 1'b0);
      pulse(1'b1);
      chk("cpu halted", 32'(cpu_run), 32'h0);
      rd("halt status", scm_pkg::ADR_STAT, 8'h06, 8'h06);
      measure();
      chk("fh kept", 32'(n_fh > 0), 32'(i[1]));
      chk("fsub kept", 32'(n_fsub > 0), 32'(i[0]));
      chk("sys kept", 32'(n_sys > 0), 32'(i[2] ? i[0] : i[1]));
      chk("slow rc kept", 32'(n_lrc > 0), 32'(i[1:0] != 0 || i[2]));
      pulse(1'b0);
      chk("cpu running", 32'(cpu_run), 32'h1);
      rd("run status", scm_pkg::ADR_STAT, 8'h06, 8'h00);
      poll(scm_pkg::ADR_IRC, 1, 1'b1);
    end
    test_done();
  end
endmodule // test_system_clock_mode_control
